// ==== chip_mode_ctrl.sv ====
// Purpose: strap capture at reset and low power mode sequencing
// Assumes: core signals are on clk_in; straps, breakpoint and interrupts come from pins
// Notes:   clock gates are enable levels for downstream clock gating cells
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/100ps
module chip_mode_ctrl
   import chip_mode_pkg::*;
#(
   parameter int N_PERIPH = 8
) (
   input  wire logic                clk_in,              // system clock 125 MHz
   input  wire logic                reset_n_in,          // sync reset, active low
   // straps
   input  wire logic                config_strap_enable_n_in, // strap enable, active low
   input  wire logic                op_mode_strap_in,    // operating mode strap
   input  wire logic [1:0]          boot_width_strap_in, // boot width straps
   input  wire logic                drive_strap_in,      // pad drive strap
   input  wire logic                clock_mode_sel_hi_in, // clock mode strap high
   input  wire logic                clock_mode_sel_lo_in, // clock mode strap low
   input  wire logic [1:0]          cs_split_strap_in,   // chip select straps
   input  wire logic                debug_sel_strap_in,  // debug port select strap
   // wakeup and core
   input  wire logic                breakpoint_pin_n_in, // breakpoint pin, active low
   input  wire logic                irq_valid_in,        // valid interrupt request (pin)
   input  wire logic                stop_exec_in,        // core executed stop, one pulse
   // register port
   input  wire logic [ADDR_W-1:0]   addr_in,             // word address
   input  wire logic [31:0]         wdata_in,            // write data
   input  wire logic                wr_in,               // write strobe
   input  wire logic                rd_in,               // read strobe
   output logic      [31:0]         rdata_out,           // read data, next cycle
   // configuration results
   output logic                     master_mode_out,     // 1 master
   output logic [1:0]               boot_width_out,      // boot width code
   output logic                     full_drive_out,      // 1 full drive
   output logic [1:0]               clock_mode_out,      // clock source code
   output logic [2:0]               addr_pin_is_cs_out,  // per upper pin: 1 chip select
   output logic                     chip_select_six_out, // top pin is chip select 6
   output logic                     scan_port_sel_out,   // 1 scan port, 0 debug port
   output logic                     background_debug_port_en_out, // debug port owns pins
   // low power
   output logic [1:0]               low_power_mode_field_out, // programmed field
   output logic [1:0]               power_state_out,     // current mode
   output logic                     core_clk_en_out,     // core clock enable
   output logic                     mem_clk_en_out,      // memory clock enable
   output logic                     sys_clk_en_out,      // system clock enable, low in stop
   output logic [N_PERIPH-1:0]      periph_clk_en_out,   // per peripheral clock enable
   output logic                     doze_out,            // peripherals: in doze
   output logic                     bus_clock_out_en_out // bus clock output enable
);

   // ------------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------------
   if (N_PERIPH < 1 || N_PERIPH > 32) begin : g_bad_n
      $error("N_PERIPH must be 1..32");
   end

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   localparam int SW = 12;
   logic [SW-1:0] pins_sync;

   strap_sync #(
      .WIDTH (SW)
   ) u_sync (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .async_in   ({config_strap_enable_n_in, op_mode_strap_in, boot_width_strap_in,
                    drive_strap_in, clock_mode_sel_hi_in, clock_mode_sel_lo_in,
                    cs_split_strap_in, debug_sel_strap_in, breakpoint_pin_n_in,
                    irq_valid_in}),
      .sync_out   (pins_sync)
   );

   logic       s_en_n;
   logic       s_mode;
   logic [1:0] s_boot;
   logic       s_drive;
   logic [1:0] s_clk;
   logic [1:0] s_cs;
   logic       s_dbg;
   logic       breakpoint_pin_n_n_sync;
   logic       irq_sync;

   assign s_en_n      = pins_sync[11];
   assign s_mode      = pins_sync[10];
   assign s_boot      = pins_sync[9:8];
   assign s_drive     = pins_sync[7];
   assign s_clk       = pins_sync[6:5];
   assign s_cs        = pins_sync[4:3];
   assign s_dbg       = pins_sync[2];
   assign breakpoint_pin_n_n_sync = pins_sync[1];
   assign irq_sync    = pins_sync[0];

   // ------------------------------------------------------------------
   // strap capture
   // ------------------------------------------------------------------
   // during reset the synchroniser is also held, so straps are captured once,
   // on the third edge after release, when the synchronised levels are valid;
   // frozen afterwards so mid-run strap changes are ignored
   logic       cfg_frozen;
   logic [1:0] settle;
   logic       cfg_master;
   logic [1:0] cfg_boot;
   logic       cfg_drive;
   logic [1:0] cfg_clk;
   logic [1:0] cfg_cs;
   logic       cfg_dbg;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         cfg_frozen <= 1'b0;
         settle     <= 2'h0;
         cfg_master <= DEF_MASTER;
         cfg_boot   <= DEF_BOOT;
         cfg_drive  <= DEF_FULL_DRIVE;
         cfg_clk    <= DEF_CLK_MODE;
         cfg_cs     <= DEF_CS_SPLIT;
         cfg_dbg    <= 1'b0;
      end else if (!cfg_frozen) begin
         settle <= settle + 2'h1;
         if (settle == 2'h2) begin
            cfg_frozen <= 1'b1;
            cfg_dbg    <= s_dbg;
            if (!s_en_n) begin
               cfg_master <= s_mode;
               cfg_boot   <= s_boot;
               cfg_drive  <= s_drive;
               cfg_clk    <= s_clk;
               cfg_cs     <= s_cs;
            end
         end
      end
   end

   always_comb begin
      unique case (cfg_boot)
         BOOT_W8:  boot_width_out = BOOT_W8;
         BOOT_W16: boot_width_out = BOOT_W16;
         BOOT_W32, BOOT_W32_ALT: boot_width_out = BOOT_W32;
      endcase
   end

   always_comb begin
      unique case (cfg_cs)
         CS_ONE:   addr_pin_is_cs_out = 3'h4;
         CS_TWO:   addr_pin_is_cs_out = 3'h6;
         CS_THREE: addr_pin_is_cs_out = 3'h7;
         CS_NONE:  addr_pin_is_cs_out = 3'h0;
      endcase
   end

   assign master_mode_out              = cfg_master;
   assign full_drive_out               = cfg_drive;
   assign clock_mode_out               = cfg_clk;
   assign chip_select_six_out          = addr_pin_is_cs_out[2];
   assign scan_port_sel_out            = cfg_dbg;
   assign background_debug_port_en_out = ~cfg_dbg;

   // ------------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------------
   lpm_t               lpm_field;
   logic               busclk_off;
   logic               dbg_req;
   logic [N_PERIPH-1:0] periph_dis;
   lpm_t               state;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         lpm_field  <= lpm_t'(RST_LPM);
         busclk_off <= RST_BUSCLK_OFF;
         periph_dis <= '0;
      end else if (wr_in) begin
         if (addr_in == OFS_LP_CTRL) begin
            lpm_field  <= lpm_t'(wdata_in[LPC_LPM_LO +: 2]);
            busclk_off <= wdata_in[LPC_BUSCLK_OFF];
         end
         if (addr_in == OFS_PERIPH_DIS)
            periph_dis <= wdata_in[N_PERIPH-1:0];
      end
   end

   // debug request: set by software, cleared by hardware when it wakes
   always_ff @(posedge clk_in) begin
      if (!reset_n_in)
         dbg_req <= 1'b0;
      else if (wr_in && addr_in == OFS_LP_CTRL && wdata_in[LPC_DBG_REQ])
         dbg_req <= 1'b1;
      else if (state != LPM_RUN)
         dbg_req <= 1'b0;
   end

   // ------------------------------------------------------------------
   // low power state machine
   // ------------------------------------------------------------------
   lpm_t next_state;
   logic wake;

   assign wake = ~breakpoint_pin_n_n_sync | dbg_req | irq_sync;

   always_comb begin
      next_state = state;
      unique case (state)
         LPM_RUN: begin
            if (stop_exec_in)
               next_state = lpm_field;
         end
         LPM_WAIT, LPM_DOZE, LPM_STOP: begin
            if (wake)
               next_state = LPM_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in)
         state <= LPM_RUN;
      else
         state <= next_state;
   end

   // ------------------------------------------------------------------
   // clock enables
   // ------------------------------------------------------------------
   logic in_low;
   logic in_stop;
   assign in_low  = (state != LPM_RUN);
   assign in_stop = (state == LPM_STOP);

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         core_clk_en_out <= 1'b1;
         mem_clk_en_out  <= 1'b1;
         sys_clk_en_out  <= 1'b1;
      end else begin
         core_clk_en_out <= ~(next_state != LPM_RUN);
         mem_clk_en_out  <= ~(next_state != LPM_RUN);
         sys_clk_en_out  <= ~(next_state == LPM_STOP);
      end
   end

   // peripheral enables keep state; gated clocks freeze them in stop
   genvar gi;
   for (gi = 0; gi < N_PERIPH; gi++) begin : g_periph
      always_ff @(posedge clk_in) begin
         if (!reset_n_in)
            periph_clk_en_out[gi] <= 1'b1;
         else
            periph_clk_en_out[gi] <= ~periph_dis[gi] & ~(next_state == LPM_STOP);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         bus_clock_out_en_out <= 1'b1;
         doze_out             <= 1'b0;
      end else begin
         bus_clock_out_en_out <= ~busclk_off & ~(next_state == LPM_STOP);
         doze_out             <= (next_state == LPM_DOZE);
      end
   end

   assign low_power_mode_field_out = lpm_field;
   assign power_state_out          = state;

   // ------------------------------------------------------------------
   // register read
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in)
         rdata_out <= 32'h0;
      else if (rd_in) begin
         rdata_out <= 32'h0;
         unique case (addr_in)
            OFS_LP_CTRL:    rdata_out[3:0] <= {dbg_req, busclk_off, lpm_field};
            OFS_PERIPH_DIS: rdata_out[N_PERIPH-1:0] <= periph_dis;
            OFS_STATUS:     rdata_out[3:0] <= {in_stop, in_low, state};
            OFS_STRAPS:     rdata_out[11:0] <= {cfg_frozen, cfg_dbg, cfg_cs, cfg_clk,
                                                cfg_drive, boot_width_out, cfg_master, 2'h0};
            default:        rdata_out <= 32'h0;
         endcase
      end
   end

endmodule : chip_mode_ctrl

// ==== chip_mode_pkg.sv ====
// Purpose: shared constants for chip mode configuration and low power control
// Assumes: one system clock, synchronous active-low reset
// Notes:   register offsets are word indices on the plain register port
package chip_mode_pkg;

   // ------------------------------------------------------------------
   // low power mode field encodings
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      LPM_RUN  = 2'h0,
      LPM_DOZE = 2'h1,
      LPM_WAIT = 2'h2,
      LPM_STOP = 2'h3
   } lpm_t;

   // ------------------------------------------------------------------
   // strap encodings and defaults
   // ------------------------------------------------------------------
   localparam logic [1:0] BOOT_W32     = 2'h0;
   localparam logic [1:0] BOOT_W16     = 2'h1;
   localparam logic [1:0] BOOT_W8      = 2'h2;
   localparam logic [1:0] BOOT_W32_ALT = 2'h3;
   localparam logic [1:0] CLK_EXT_NOPLL = 2'h0;
   localparam logic [1:0] CLK_PLL_1TO1  = 2'h1;
   localparam logic [1:0] CLK_PLL_EXTREF = 2'h2;
   localparam logic [1:0] CLK_PLL_XTAL  = 2'h3;
   localparam logic [1:0] CS_NONE      = 2'h0;
   localparam logic [1:0] CS_ONE       = 2'h2;
   localparam logic [1:0] CS_TWO       = 2'h1;
   localparam logic [1:0] CS_THREE     = 2'h3;

   localparam logic       DEF_MASTER   = 1'b1;
   localparam logic [1:0] DEF_BOOT     = BOOT_W32;
   localparam logic       DEF_FULL_DRIVE = 1'b0;
   localparam logic [1:0] DEF_CLK_MODE = CLK_PLL_XTAL;
   localparam logic [1:0] DEF_CS_SPLIT = CS_NONE;

   // ------------------------------------------------------------------
   // register map (word addresses) and reset values
   // ------------------------------------------------------------------
   localparam int         ADDR_W          = 4;
   localparam logic [3:0] OFS_LP_CTRL     = 4'h0;
   localparam logic [3:0] OFS_PERIPH_DIS  = 4'h1;
   localparam logic [3:0] OFS_STATUS      = 4'h2;
   localparam logic [3:0] OFS_STRAPS      = 4'h3;
   localparam logic [1:0] RST_LPM         = 2'h0;
   localparam logic       RST_BUSCLK_OFF  = 1'b0;

   // bit positions in the low power control register
   localparam int LPC_LPM_LO     = 0;
   localparam int LPC_BUSCLK_OFF = 2;
   localparam int LPC_DBG_REQ    = 3;

endpackage : chip_mode_pkg

// ==== strap_sync.sv ====
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: pins are asynchronous to clk_in
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module strap_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_in,     // system clock
   input  wire logic             reset_n_in, // sync reset, active low
   input  wire logic [WIDTH-1:0] async_in,   // raw pin levels
   output logic      [WIDTH-1:0] sync_out    // synchronised levels
);

   if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule : strap_sync

// ==== board_core_model.sv ====
// Purpose: board strap drivers and the core's stop signalling
// Assumes: straps are plain levels that the board holds steady
// Notes:   stop pulse follows the request directly, one clock long
`timescale 1ns/100ps
module board_core_model (
   input  wire logic [9:0] cfg_in,       // wanted strap levels
   input  wire logic       stop_req_in,  // software asks for stop
   output logic      [9:0] straps_out,   // strap pin levels
   output logic            stop_exec_out // core executed stop
);
   // board drives every strap pin, enable included, for the whole reset
   assign straps_out = cfg_in;
   // requested only after the bench has finished its field write and bus work
   assign stop_exec_out = stop_req_in;
endmodule : board_core_model

// ==== chip_mode_checker.sv ====
// Purpose: assertions on strap capture and low power sequencing
// Assumes: one clock domain, sync active-low reset
// Notes:   wake bounds allow for the two-flop pin synchroniser
`timescale 1ns/100ps
module chip_mode_checker
   import chip_mode_pkg::*;
#(
   parameter int N_PERIPH = 8
) (
   input wire logic                clk_in,                       // clock
   input wire logic                reset_n_in,                   // reset
   input wire logic                breakpoint_pin_n_in,          // wake pin
   input wire logic                irq_valid_in,                 // wake irq
   input wire logic                stop_exec_in,                 // stop pulse
   input wire logic                wr_in,                        // write strobe
   input wire logic                master_mode_out,              // mode
   input wire logic [1:0]          boot_width_out,               // boot
   input wire logic                full_drive_out,               // drive
   input wire logic [1:0]          clock_mode_out,               // clock mode
   input wire logic [2:0]          addr_pin_is_cs_out,           // cs split
   input wire logic                chip_select_six_out,          // top cs
   input wire logic                scan_port_sel_out,            // scan
   input wire logic                background_debug_port_en_out, // debug
   input wire logic [1:0]          low_power_mode_field_out,     // field
   input wire logic [1:0]          power_state_out,              // state
   input wire logic                core_clk_en_out,              // core en
   input wire logic                mem_clk_en_out,               // mem en
   input wire logic                sys_clk_en_out,               // sys en
   input wire logic [N_PERIPH-1:0] periph_clk_en_out,            // periph en
   input wire logic                doze_out                      // doze
);
   // ----------------------------------------
   // edges since reset release, saturating
   // ----------------------------------------
   logic [2:0] since_rst;
   always_ff @(posedge clk_in) begin
      if (!reset_n_in)
         since_rst <= 3'h0;
      else if (since_rst != 3'h7)
         since_rst <= since_rst + 3'h1;
   end
   wire logic [9:0] cfg_now = {master_mode_out, boot_width_out, full_drive_out,
                               clock_mode_out, addr_pin_is_cs_out, scan_port_sel_out};
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_stop_taken;
      stop_exec_in && power_state_out == LPM_RUN;
   endsequence
   sequence s_wake_held;
      (power_state_out != LPM_RUN && (irq_valid_in || !breakpoint_pin_n_in)) [*2];
   endsequence
   a_stop_entry: assert property (
      s_stop_taken |=> power_state_out == $past(low_power_mode_field_out))
      else $error("stop did not enter the programmed mode");
   a_wake_bound: assert property (s_wake_held |-> ##[0:4] power_state_out == LPM_RUN)
      else $error("wake event did not return to run");
   a_no_spurious: assert property (
      (!irq_valid_in && breakpoint_pin_n_in && !wr_in) [*4] ##0 power_state_out != LPM_RUN
      |=> power_state_out != LPM_RUN) else $error("left low power with no wake event");
   a_stop_gating: assert property (power_state_out == LPM_STOP |->
      !sys_clk_en_out && !core_clk_en_out && periph_clk_en_out == '0)
      else $error("clocks running in stop");
   a_wait_gating: assert property (power_state_out == LPM_WAIT |->
      !core_clk_en_out && !mem_clk_en_out && sys_clk_en_out && !doze_out)
      else $error("wait gating wrong");
   a_doze_gating: assert property (power_state_out == LPM_DOZE |->
      doze_out && !core_clk_en_out && !mem_clk_en_out && sys_clk_en_out)
      else $error("doze gating wrong");
   a_run_clocks: assert property (power_state_out == LPM_RUN |->
      core_clk_en_out && mem_clk_en_out && sys_clk_en_out && !doze_out)
      else $error("clocks gated in run");
   a_straps_frozen: assert property (since_rst == 3'h7 |-> $stable(cfg_now))
      else $error("configuration changed after capture");
   a_cs_split: assert property (chip_select_six_out == addr_pin_is_cs_out[2] &&
      addr_pin_is_cs_out inside {3'h0, 3'h4, 3'h6, 3'h7}) else $error("bad pin split");
   a_debug_owner: assert property (background_debug_port_en_out != scan_port_sel_out)
      else $error("debug pins owned twice or not at all");
endmodule : chip_mode_checker

bind chip_mode_ctrl chip_mode_checker #(.N_PERIPH(N_PERIPH)) i_chip_mode_checker (.*);

// ==== chip_mode_config_and_low_power_bench.sv ====
// Purpose: self-checking bench for strap capture and low power control
// Assumes: 125 MHz clock; straps and stop pulse come from board_core_model
// Notes:   strap rows first, then low power, wake and register cases
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module chip_mode_config_and_low_power_bench
   import chip_mode_pkg::*;
;
   typedef struct packed {logic [9:0] straps; logic [9:0] want;} row_t;
   logic        clk_in = 1'b0, reset_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
   logic        irq_valid_in = 1'b0, breakpoint_pin_n_in = 1'b1, stop_req = 1'b0;
   logic [3:0]  addr_in = 4'h0;
   logic [31:0] wdata_in = 32'h0, rdata_out;
   logic [9:0]  cfg = 10'h000, straps;
   logic        config_strap_enable_n_in, op_mode_strap_in, drive_strap_in, stop_exec_in;
   logic        clock_mode_sel_hi_in, clock_mode_sel_lo_in, debug_sel_strap_in;
   logic [1:0]  boot_width_strap_in, cs_split_strap_in;
   logic        master_mode_out, full_drive_out, chip_select_six_out, scan_port_sel_out;
   logic        background_debug_port_en_out, core_clk_en_out, mem_clk_en_out;
   logic        sys_clk_en_out, doze_out, bus_clock_out_en_out;
   logic [1:0]  boot_width_out, clock_mode_out, low_power_mode_field_out, power_state_out;
   logic [2:0]  addr_pin_is_cs_out;
   logic [7:0]  periph_clk_en_out;
   int          miscompares = 0, n_checks = 0;
   // strap bundle {enable_n, mode, boot[1:0], drive, clk hi, clk lo, cs[1:0], debug}
   row_t rows [5] = '{'{10'h121, 10'h241}, '{10'h14C, 10'h298}, '{10'h1B3, 10'h36D},
                      '{10'h1DE, 10'h23E}, '{10'h2A7, 10'h231}};
   assign {config_strap_enable_n_in, op_mode_strap_in, boot_width_strap_in, drive_strap_in,
           clock_mode_sel_hi_in, clock_mode_sel_lo_in, cs_split_strap_in,
           debug_sel_strap_in} = straps;
   wire logic [9:0] cfg_seen = {master_mode_out, boot_width_out, full_drive_out,
                                clock_mode_out, addr_pin_is_cs_out, scan_port_sel_out};
   wire logic [1:0] pins_seen = {chip_select_six_out, background_debug_port_en_out};
   always #4 clk_in = ~clk_in;
   board_core_model i_board_core_model (.cfg_in(cfg), .stop_req_in(stop_req),
      .straps_out(straps), .stop_exec_out(stop_exec_in));
   chip_mode_ctrl #(.N_PERIPH(8)) i_chip_mode_ctrl (.*);
   // ----------------------------------------
   // bus and stop helpers
   // ----------------------------------------
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in    <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      #1 d = rdata_out;
   endtask : reg_rd
   task automatic pulse_stop(input int settle);
      @(posedge clk_in);
      stop_req <= 1'b1;
      @(posedge clk_in);
      stop_req <= 1'b0;
      repeat (settle) @(posedge clk_in);
      #1;
   endtask : pulse_stop
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      logic [31:0] d;
      logic [1:0]  m;
      foreach (rows[r]) begin
         @(posedge clk_in);
         cfg        <= rows[r].straps;
         reset_n_in <= 1'b0;
         repeat (3) @(posedge clk_in);
         #1;
         `CHK(cfg_seen, 10'h230)
         `CHK({power_state_out, sys_clk_en_out, doze_out, rdata_out}, {4'h2, 32'h0})
         @(posedge clk_in);
         reset_n_in <= 1'b1;
         repeat (6) @(posedge clk_in);
         #1;
         `CHK(cfg_seen, rows[r].want)
         `CHK(pins_seen, {rows[r].want[3], ~rows[r].want[0]})
         @(posedge clk_in);
         cfg <= ~rows[r].straps;
         repeat (5) @(posedge clk_in);
         #1;
         `CHK(cfg_seen, rows[r].want)
         $display("strap row %0d done", r);
      end
      reg_wr(OFS_PERIPH_DIS, 32'h5);
      @(posedge clk_in);
      #1;
      `CHK(periph_clk_en_out, 8'hFA)
      for (int k = 1; k < 4; k++) begin
         m = 2'(k);
         reg_wr(OFS_LP_CTRL, {30'h0, m});
         pulse_stop(8);
         `CHK({power_state_out, low_power_mode_field_out}, {m, m})
         `CHK({core_clk_en_out, mem_clk_en_out, doze_out}, {2'b00, m == LPM_DOZE})
         `CHK({sys_clk_en_out, bus_clock_out_en_out}, {2{m != LPM_STOP}})
         `CHK(periph_clk_en_out, (m == LPM_STOP) ? 8'h00 : 8'hFA)
         reg_rd(OFS_STATUS, d);
         `CHK(d[3:0], {m == LPM_STOP, 1'b1, m})
         // each mode leaves by a different wake source
         if (k == 3)
            reg_wr(OFS_LP_CTRL, {28'h0, 2'b10, m});
         else begin
            @(posedge clk_in);
            irq_valid_in        <= (k == 1);
            breakpoint_pin_n_in <= (k != 2);
         end
         for (int i = 0; i < 10 && power_state_out !== LPM_RUN; i++)
            @(posedge clk_in);
         #1;
         `CHK({power_state_out, core_clk_en_out, periph_clk_en_out}, {3'h1, 8'hFA})
         @(posedge clk_in);
         irq_valid_in        <= 1'b0;
         breakpoint_pin_n_in <= 1'b1;
         repeat (4) @(posedge clk_in);
         $display("low power mode %0d done", m);
      end
      // field left at run: stop must not leave run; bus clock output off alone
      reg_wr(OFS_LP_CTRL, 32'h4);
      pulse_stop(3);
      `CHK({power_state_out, core_clk_en_out, bus_clock_out_en_out}, 4'h2)
      reg_rd(OFS_LP_CTRL, d);
      `CHK(d, 32'h4)
      reg_wr(OFS_LP_CTRL, 32'h0);
      reg_rd(OFS_PERIPH_DIS, d);
      `CHK(d, 32'h5)
      reg_rd(4'hF, d);
      `CHK(d, 32'h0)
      // last row ran with the enable high: defaults, debug strap high, frozen
      reg_rd(OFS_STRAPS, d);
      `CHK(d, 32'hCC4)
      $display("register cases done");
      close_out();
   end
   // whole run is under two hundred cycles; this bound only catches a hang
   initial begin
      repeat (4000) @(posedge clk_in);
      miscompares++;
      close_out();
   end
endmodule : chip_mode_config_and_low_power_bench
